// [verilog/vamr_pkg.sv]
// Overview of operation
// - read-only 32-bit fully-open time counter
// - read-only 32-bit fully-closed time counter
// - counters tick minutes, or hours in legacy
// - 32-bit count of successful power-ups
// - read-only 32-bit unit serial number
// - analog input scaled 0-200 or 0-50
// - fixed project and document id registers
// - version byte-coded whole and fraction
// - sticky fault history with live flag map
// - reserved pair reads zero, read-only
// - valve type 0-2, else exception
// - control type reads 0 on/off, 1 proportional
// - control source 0-1, else exception
// - serial faults suppressed unless serial source
// - loss position 0-100 used on lost input
// - deadband 0-100 hysteresis on demand
// - demand below cutoff forced to zero
// - serial timeout faults, zero disables
// - valid message clears timeout, takes demand
// - address 1-247 stored, used next power-up
// - baud 4-6 stored, used next power-up
package vamr_pkg;
    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [15:0] OFS_OPEN_TIME  = 16'h0010;
    localparam logic [15:0] OFS_CLOSE_TIME = 16'h0012;
    localparam logic [15:0] OFS_POWER_UP   = 16'h0014;
    localparam logic [15:0] OFS_SERIAL     = 16'h0016;
    localparam logic [15:0] OFS_ANALOG     = 16'h0018;
    localparam logic [15:0] OFS_PROJ_ID    = 16'h0019;
    localparam logic [15:0] OFS_DOC_ID     = 16'h001a;
    localparam logic [15:0] OFS_FW_VER     = 16'h001b;
    localparam logic [15:0] OFS_FAULT_HIST = 16'h001c;
    localparam logic [15:0] OFS_RSVD_LO    = 16'h001d;
    localparam logic [15:0] OFS_RSVD_HI    = 16'h001e;
    localparam logic [15:0] OFS_VALVE_TYPE = 16'h001f;
    localparam logic [15:0] OFS_CTRL_TYPE  = 16'h0020;
    localparam logic [15:0] OFS_CTRL_SRC   = 16'h0021;
    localparam logic [15:0] OFS_LOSS_POS   = 16'h0022;
    localparam logic [15:0] OFS_DEADBAND   = 16'h0023;
    localparam logic [15:0] OFS_CUTOFF     = 16'h0024;
    localparam logic [15:0] OFS_TIMEOUT    = 16'h0025;
    localparam logic [15:0] OFS_ADDRESS    = 16'h0026;
    localparam logic [15:0] OFS_BAUD       = 16'h0027;
    // ------------------------------------------------------------
    // legal ranges and reset values
    // ------------------------------------------------------------
    localparam logic [15:0] VALVE_TYPE_MAX = 16'h0002;
    localparam logic [15:0] CTRL_SRC_MAX   = 16'h0001;
    localparam logic [15:0] PERCENT_MAX    = 16'h0064;
    localparam logic [15:0] ADDR_MIN       = 16'h0001;
    localparam logic [15:0] ADDR_MAX       = 16'h00f7;
    localparam logic [15:0] BAUD_MIN       = 16'h0004;
    localparam logic [15:0] BAUD_MAX       = 16'h0006;
    localparam logic [15:0] RST_ADDRESS    = 16'h0001;
    localparam logic [15:0] RST_BAUD       = 16'h0004;
    localparam logic [15:0] RST_TIMEOUT    = 16'h0000;
    localparam logic [15:0] SRC_SERIAL     = 16'h0000;
    localparam logic [15:0] ANALOG_MA_MAX  = 16'h00c8;
    localparam logic [15:0] ANALOG_V_MAX   = 16'h0032;
    localparam logic [7:0]  EXC_DEVICE_FAIL = 8'h04;
    // fault bit raised on serial timeout in the sticky fault history
    localparam int          FAULT_BIT_TIMEOUT = 7;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLOCK_HZ        = 100_000_000;
    localparam int SECOND_S        = 1;
    localparam int CYCLES_PER_SEC  = CLOCK_HZ * SECOND_S;
    localparam int SECONDS_PER_MIN = 60;
    localparam int MINUTES_PER_HR  = 60;
endpackage

// [verilog/vamr_regs.sv]
module vamr_regs
    import vamr_pkg::*;
#(
    parameter int        SEC_CYCLES    = CYCLES_PER_SEC,
    parameter logic      UNITS_MINUTES = 1'b1,
    parameter logic [31:0] SERIAL_NUM  = 32'h0000_0001,
    parameter logic [15:0] PROJECT_ID  = 16'h00a5, // arbitrary value
    parameter logic [15:0] DOCUMENT_ID = 16'h005a, // arbitrary value
    parameter logic [15:0] FW_VERSION  = 16'h0110, // arbitrary value
    parameter logic      PROPORTIONAL  = 1'b1,
    parameter logic      INPUT_CURRENT = 1'b1
)(
    // clock and reset
    input  wire logic        CLOCK,
    input  wire logic        SRST,
    // register access from the serial frame engine
    input  wire logic        REG_RD,
    input  wire logic        REG_WR,
    input  wire logic [15:0] REG_ADDR,
    input  wire logic [15:0] REG_WDATA,
    output logic      [15:0] REG_RDATA,
    output logic             REG_ACK,
    output logic             REG_EXC,
    output logic      [7:0]  REG_EXC_CODE,
    // link activity
    input  wire logic        MSG_VALID,
    input  wire logic [15:0] MSG_DEMAND,
    // plant inputs (asynchronous)
    input  wire logic        VALVE_OPEN,
    input  wire logic        VALVE_CLOSED,
    input  wire logic        POWER_UP_OK,
    input  wire logic        ANALOG_OK,
    input  wire logic [15:0] ANALOG_RAW,
    input  wire logic [15:0] LIVE_FAULTS,
    input  wire logic [15:0] LOCAL_DEMAND,
    // outputs to position control
    output logic      [15:0] POS_TARGET,
    output logic             COMM_TIMEOUT,
    output logic      [15:0] STATION_ADDR,
    output logic      [15:0] BAUD_SEL,
    output logic      [15:0] FAULT_HISTORY
);
    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    logic [3:0]  sync_a;
    logic [3:0]  sync_b;
    logic [15:0] ana_a;
    logic [15:0] ana_b;
    logic [15:0] live_a;
    logic [15:0] live_b;
    logic [15:0] loc_a;
    logic [15:0] loc_b;
    // two stages; only the second is read by logic
    // cleared in reset so the sticky history never ors in unknown bits
    always_ff @(posedge CLOCK)
    begin
        if (SRST)
        begin
            sync_a <= 4'h0;
            sync_b <= 4'h0;
            ana_a  <= 16'h0000;
            ana_b  <= 16'h0000;
            live_a <= 16'h0000;
            live_b <= 16'h0000;
            loc_a  <= 16'h0000;
            loc_b  <= 16'h0000;
        end
        else
        begin
            sync_a <= {ANALOG_OK, POWER_UP_OK, VALVE_CLOSED, VALVE_OPEN};
            sync_b <= sync_a;
            ana_a  <= ANALOG_RAW;
            ana_b  <= ana_a;
            live_a <= LIVE_FAULTS;
            live_b <= live_a;
            loc_a  <= LOCAL_DEMAND;
            loc_b  <= loc_a;
        end
    end
    // ------------------------------------------------------------
    // time base: seconds, then minutes, then hours
    // ------------------------------------------------------------
    logic [31:0] sec_cnt;
    logic [5:0]  min_cnt;
    logic [5:0]  hr_cnt;
    wire  sec_tick  = (sec_cnt == 32'(SEC_CYCLES - 1));
    wire  min_tick  = sec_tick && (min_cnt == 6'(SECONDS_PER_MIN - 1));
    wire  hr_tick   = min_tick && (hr_cnt == 6'(MINUTES_PER_HR - 1));
    wire  unit_tick = UNITS_MINUTES ? min_tick : hr_tick;
    always_ff @(posedge CLOCK)
    begin
        if (SRST)
        begin
            sec_cnt <= 32'h0000_0000;
            min_cnt <= 6'h00;
            hr_cnt  <= 6'h00;
        end
        else
        begin
            sec_cnt <= sec_tick ? 32'h0000_0000 : sec_cnt + 32'h0000_0001;
            if (sec_tick)
                min_cnt <= min_tick ? 6'h00 : min_cnt + 6'h01;
            if (min_tick)
                hr_cnt <= hr_tick ? 6'h00 : hr_cnt + 6'h01;
        end
    end
    // ------------------------------------------------------------
    // statistics counters; nonvolatile, so not cleared by SRST
    // ------------------------------------------------------------
    logic [31:0] open_time;
    logic [31:0] closed_time;
    logic [31:0] power_ups;
    logic        pwr_q;
    logic        stats_init = 1'b0; // defined start; never touched by SRST
    wire  pwr_rise = sync_b[2] && !pwr_q;
    // first cycle after the bank starts loads zero, then counts
    always_ff @(posedge CLOCK)
    begin
        pwr_q <= sync_b[2];
        if (!stats_init)
        begin
            stats_init  <= 1'b1;
            open_time   <= 32'h0000_0000;
            closed_time <= 32'h0000_0000;
            power_ups   <= 32'h0000_0000;
        end
        else
        begin
            if (unit_tick && sync_b[0])
                open_time <= open_time + 32'h0000_0001;
            if (unit_tick && sync_b[1])
                closed_time <= closed_time + 32'h0000_0001;
            if (pwr_rise)
                power_ups <= power_ups + 32'h0000_0001;
        end
    end
    // ------------------------------------------------------------
    // 32-bit snapshot: reading the low word latches the high word
    // so a single multi-register read is coherent
    // ------------------------------------------------------------
    logic [15:0] hi_snap;
    // ------------------------------------------------------------
    // configuration registers and write checks
    // ------------------------------------------------------------
    logic [15:0] valve_type;
    logic [15:0] ctrl_src;
    logic [15:0] loss_pos;
    logic [15:0] deadband;
    logic [15:0] cutoff;
    logic [15:0] timeout_s;
    logic [15:0] addr_store;
    logic [15:0] baud_store;
    wire  [15:0] wd = REG_WDATA;
    wire  wr_ok =
        (REG_ADDR == OFS_VALVE_TYPE) ? (wd <= VALVE_TYPE_MAX) :
        (REG_ADDR == OFS_CTRL_SRC)   ? (wd <= CTRL_SRC_MAX) :
        (REG_ADDR == OFS_LOSS_POS)   ? (wd <= PERCENT_MAX) :
        (REG_ADDR == OFS_DEADBAND)   ? (wd <= PERCENT_MAX) :
        (REG_ADDR == OFS_CUTOFF)     ? (wd <= PERCENT_MAX) :
        (REG_ADDR == OFS_TIMEOUT)    ? 1'b1 :
        (REG_ADDR == OFS_ADDRESS)    ? (wd >= ADDR_MIN && wd <= ADDR_MAX) :
        (REG_ADDR == OFS_BAUD)       ? (wd >= BAUD_MIN && wd <= BAUD_MAX) :
        1'b0;
    wire  do_wr = REG_WR && wr_ok;
    always_ff @(posedge CLOCK)
    begin
        if (SRST)
        begin
            valve_type <= 16'h0000;
            ctrl_src   <= SRC_SERIAL;
            loss_pos   <= 16'h0000;
            deadband   <= 16'h0000;
            cutoff     <= 16'h0000;
            timeout_s  <= RST_TIMEOUT;
            addr_store <= RST_ADDRESS;
            baud_store <= RST_BAUD;
        end
        else if (do_wr)
        begin
            case (REG_ADDR)
                OFS_VALVE_TYPE: valve_type <= wd;
                OFS_CTRL_SRC:   ctrl_src   <= wd;
                OFS_LOSS_POS:   loss_pos   <= wd;
                OFS_DEADBAND:   deadband   <= wd;
                OFS_CUTOFF:     cutoff     <= wd;
                OFS_TIMEOUT:    timeout_s  <= wd;
                OFS_ADDRESS:    addr_store <= wd;
                OFS_BAUD:       baud_store <= wd;
                default:        ;
            endcase
        end
    end
    // address and baud are taken only at the power-up edge
    always_ff @(posedge CLOCK)
    begin
        if (SRST)
        begin
            STATION_ADDR <= RST_ADDRESS;
            BAUD_SEL     <= RST_BAUD;
        end
        else if (pwr_rise)
        begin
            STATION_ADDR <= addr_store;
            BAUD_SEL     <= baud_store;
        end
    end
    // ------------------------------------------------------------
    // analog scaling: raw is 0-65535 full scale
    // ------------------------------------------------------------
    wire  [15:0] ana_full  = INPUT_CURRENT ? ANALOG_MA_MAX : ANALOG_V_MAX;
    wire  [31:0] ana_prod  = ana_b * ana_full;
    wire  [15:0] ana_scaled = ana_prod[31:16];
    // ------------------------------------------------------------
    // communications timeout
    // ------------------------------------------------------------
    logic [15:0] idle_sec;
    logic [15:0] serial_demand;
    wire  serial_sel = (ctrl_src == SRC_SERIAL);
    wire  tmo_hit    = serial_sel && (timeout_s != 16'h0000)
                       && (idle_sec >= timeout_s);
    always_ff @(posedge CLOCK)
    begin
        if (SRST)
        begin
            idle_sec      <= 16'h0000;
            COMM_TIMEOUT  <= 1'b0;
            serial_demand <= 16'h0000;
        end
        else
        begin
            if (MSG_VALID)
            begin
                idle_sec      <= 16'h0000;
                COMM_TIMEOUT  <= 1'b0;
                serial_demand <= MSG_DEMAND;
            end
            else
            begin
                if (sec_tick && idle_sec != 16'hffff)
                    idle_sec <= idle_sec + 16'h0001;
                // suppressed when serial is not the source
                COMM_TIMEOUT <= tmo_hit;
            end
        end
    end
    // ------------------------------------------------------------
    // demand path: source, loss position, deadband, cutoff
    // ------------------------------------------------------------
    logic [15:0] held_demand;
    wire  lost      = serial_sel ? tmo_hit : !sync_b[3];
    wire  [15:0] src_dem  = serial_sel ? serial_demand : loc_b;
    wire  [15:0] raw_dem  = lost ? loss_pos : src_dem;
    wire  [15:0] dem_diff = (raw_dem > held_demand) ? raw_dem - held_demand
                                                    : held_demand - raw_dem;
    // endpoints and lost always pass, so a full deadband gives 0/100 or loss_pos only
    wire  dem_move  = (dem_diff >= deadband) || raw_dem == 16'h0000
                      || raw_dem == PERCENT_MAX || lost;
    wire  [15:0] next_target = (held_demand < cutoff) ? 16'h0000
                                                      : held_demand;
    always_ff @(posedge CLOCK)
    begin
        if (SRST)
        begin
            held_demand <= 16'h0000;
            POS_TARGET  <= 16'h0000;
        end
        else
        begin
            if (dem_move)
                held_demand <= raw_dem;
            POS_TARGET <= next_target;
        end
    end
    // ------------------------------------------------------------
    // fault history: sticky, nonvolatile
    // ------------------------------------------------------------
    wire  [15:0] tmo_mask = 16'(COMM_TIMEOUT) << FAULT_BIT_TIMEOUT;
    always_ff @(posedge CLOCK)
    begin
        if (!stats_init)
            FAULT_HISTORY <= 16'h0000;
        else
            FAULT_HISTORY <= FAULT_HISTORY | live_b | tmo_mask;
    end
    // ------------------------------------------------------------
    // read decode and answer
    // ------------------------------------------------------------
    logic [15:0] rd_mux;
    always_comb
    begin
        case (REG_ADDR)
            OFS_OPEN_TIME:      rd_mux = open_time[15:0];
            OFS_OPEN_TIME + 16'h0001:  rd_mux = hi_snap;
            OFS_CLOSE_TIME:     rd_mux = closed_time[15:0];
            OFS_CLOSE_TIME + 16'h0001: rd_mux = hi_snap;
            OFS_POWER_UP:       rd_mux = power_ups[15:0];
            OFS_POWER_UP + 16'h0001:   rd_mux = hi_snap;
            OFS_SERIAL:         rd_mux = SERIAL_NUM[15:0];
            OFS_SERIAL + 16'h0001:     rd_mux = SERIAL_NUM[31:16];
            OFS_ANALOG:         rd_mux = ana_scaled;
            OFS_PROJ_ID:        rd_mux = PROJECT_ID;
            OFS_DOC_ID:         rd_mux = DOCUMENT_ID;
            OFS_FW_VER:         rd_mux = FW_VERSION;
            OFS_FAULT_HIST:     rd_mux = FAULT_HISTORY;
            OFS_RSVD_LO:        rd_mux = 16'h0000;
            OFS_RSVD_HI:        rd_mux = 16'h0000;
            OFS_VALVE_TYPE:     rd_mux = valve_type;
            OFS_CTRL_TYPE:      rd_mux = 16'(PROPORTIONAL);
            OFS_CTRL_SRC:       rd_mux = ctrl_src;
            OFS_LOSS_POS:       rd_mux = loss_pos;
            OFS_DEADBAND:       rd_mux = deadband;
            OFS_CUTOFF:         rd_mux = cutoff;
            OFS_TIMEOUT:        rd_mux = timeout_s;
            OFS_ADDRESS:        rd_mux = addr_store;
            OFS_BAUD:           rd_mux = baud_store;
            default:            rd_mux = 16'h0000;
        endcase
    end
    wire  rd_map = (REG_ADDR >= OFS_OPEN_TIME) && (REG_ADDR <= OFS_BAUD);
    wire  [31:0] hi_src = (REG_ADDR == OFS_OPEN_TIME)  ? open_time :
                          (REG_ADDR == OFS_CLOSE_TIME) ? closed_time : power_ups;
    // a read of the low half freezes the high half for the next word
    always_ff @(posedge CLOCK)
    begin
        if (SRST)
        begin
            REG_RDATA    <= 16'h0000;
            REG_ACK      <= 1'b0;
            REG_EXC      <= 1'b0;
            REG_EXC_CODE <= 8'h00;
            hi_snap      <= 16'h0000;
        end
        else
        begin
            REG_ACK      <= REG_RD || REG_WR;
            REG_EXC      <= (REG_WR && !wr_ok) || (REG_RD && !rd_map);
            REG_EXC_CODE <= ((REG_WR && !wr_ok) || (REG_RD && !rd_map))
                            ? EXC_DEVICE_FAIL : 8'h00;
            if (REG_RD)
                REG_RDATA <= rd_mux;
            if (REG_RD)
                hi_snap <= hi_src[31:16];
        end
    end
    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    bad_write_a: assert property (@(posedge CLOCK) disable iff (SRST)
        (REG_WR && REG_ADDR == OFS_VALVE_TYPE && REG_WDATA > VALVE_TYPE_MAX)
        |=> REG_EXC && $stable(valve_type))
        else $error("valve type accepted out of range");
    src_write_a: assert property (@(posedge CLOCK) disable iff (SRST)
        (REG_WR && REG_ADDR == OFS_CTRL_SRC && REG_WDATA > CTRL_SRC_MAX)
        |=> REG_EXC && $stable(ctrl_src))
        else $error("control source accepted out of range");
    addr_range_a: assert property (@(posedge CLOCK) disable iff (SRST)
        (REG_WR && REG_ADDR == OFS_ADDRESS && REG_WDATA == 16'h0000) |=> REG_EXC)
        else $error("address zero accepted");
    rsvd_zero_a: assert property (@(posedge CLOCK) disable iff (SRST)
        (REG_RD && REG_ADDR == OFS_RSVD_LO) |=> REG_RDATA == 16'h0000)
        else $error("reserved read not zero");
    tmo_off_a: assert property (@(posedge CLOCK) disable iff (SRST)
        (ctrl_src != SRC_SERIAL && $past(ctrl_src) != SRC_SERIAL) |-> !COMM_TIMEOUT)
        else $error("timeout while serial not selected");
    tmo_clear_a: assert property (@(posedge CLOCK) disable iff (SRST)
        MSG_VALID |=> !COMM_TIMEOUT ##0 serial_demand == $past(MSG_DEMAND))
        else $error("valid message did not clear timeout");
    cutoff_zero_a: assert property (@(posedge CLOCK) disable iff (SRST)
        (held_demand < cutoff) |=> POS_TARGET == 16'h0000)
        else $error("demand below cutoff passed");
    hist_sticky_a: assert property (@(posedge CLOCK) disable iff (SRST)
        stats_init |=> (FAULT_HISTORY & $past(FAULT_HISTORY)) == $past(FAULT_HISTORY))
        else $error("fault history bit dropped");
    loss_pos_a: assert property (@(posedge CLOCK) disable iff (SRST)
        (lost && !MSG_VALID) |=> held_demand == $past(loss_pos))
        else $error("loss position not applied");
endmodule // vamr_regs

// [testbench/vamr_master_model.sv]
module vamr_master_model
    import vamr_pkg::*;
(
    // clock
    input  wire logic        clock,
    // request towards the bank
    output logic             reg_rd,
    output logic             reg_wr,
    output logic      [15:0] reg_addr,
    output logic      [15:0] reg_wdata,
    // answer from the bank
    input  wire logic [15:0] reg_rdata,
    input  wire logic        reg_ack,
    input  wire logic        reg_exc,
    input  wire logic [7:0]  reg_exc_code
);
    timeunit 1ns;
    timeprecision 1ps;
    // -----------------------------------------
    // single transfer, strobe is one cycle wide
    // -----------------------------------------
    initial
    begin
        reg_rd = 1'b0;
        reg_wr = 1'b0;
        reg_addr = 16'h0000;
        reg_wdata = 16'h0000;
    end
    // pair halves are fetched back to back by the caller, low first
    task automatic xfer(input logic w, input logic [15:0] a, input logic [15:0] d,
                        output logic [15:0] q, output logic e, output logic [7:0] c);
        int n;
        @(negedge clock);
        reg_rd = ~w;
        reg_wr = w;
        reg_addr = a;
        reg_wdata = d;
        @(negedge clock);
        reg_rd = 1'b0;
        reg_wr = 1'b0;
        // released lines show the inverse so stale values never look valid
        reg_addr = ~a;
        reg_wdata = ~d;
        n = 0;
        while (reg_ack !== 1'b1 && n < 4)
        begin
            @(negedge clock);
            n++;
        end
        q = reg_rdata;
        e = reg_exc;
        c = reg_exc_code;
    endtask
endmodule // vamr_master_model

// [testbench/testbench.sv]
module testbench
    import vamr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // -----------------------------------------
    // signals and helpers
    // -----------------------------------------
    localparam int SEC = 10; // short second keeps minute counts reachable
    logic clock = 1'b0, srst = 1'b1, rd, wr, ack, exc, msg_v, v_open, v_closed, pwr_ok, an_ok;
    logic [15:0] addr, wdata, rdata, msg_d, an_raw, live, local_d, pos, st_addr, baud, fh, pre;
    logic [7:0]  exc_code;
    logic        c_to, pe;
    logic [31:0] seed = 32'hd7aa;
    int          failures = 0, num_checks = 0;
    logic [15:0] cfg_a [8] = '{OFS_VALVE_TYPE, OFS_CTRL_SRC, OFS_LOSS_POS, OFS_DEADBAND,
                               OFS_CUTOFF, OFS_TIMEOUT, OFS_ADDRESS, OFS_BAUD};
    int          lo [8] = '{0, 0, 0, 0, 0, 0, 1, 4};
    int          hi [8] = '{2, 1, 100, 100, 100, 65535, 247, 6};
    bit          rj [8] = '{1, 1, 1, 1, 1, 0, 1, 1};
    always #5 clock = ~clock;
    vamr_master_model u_master (.clock(clock), .reg_rd(rd), .reg_wr(wr), .reg_addr(addr),
        .reg_wdata(wdata), .reg_rdata(rdata), .reg_ack(ack), .reg_exc(exc),
        .reg_exc_code(exc_code));
    vamr_regs #(.SEC_CYCLES(SEC)) u_dut (.CLOCK(clock), .SRST(srst), .REG_RD(rd),
        .REG_WR(wr), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_RDATA(rdata), .REG_ACK(ack),
        .REG_EXC(exc), .REG_EXC_CODE(exc_code), .MSG_VALID(msg_v), .MSG_DEMAND(msg_d),
        .VALVE_OPEN(v_open), .VALVE_CLOSED(v_closed), .POWER_UP_OK(pwr_ok), .ANALOG_OK(an_ok),
        .ANALOG_RAW(an_raw), .LIVE_FAULTS(live), .LOCAL_DEMAND(local_d), .POS_TARGET(pos),
        .COMM_TIMEOUT(c_to), .STATION_ADDR(st_addr), .BAUD_SEL(baud), .FAULT_HISTORY(fh));
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic rd_q(input logic [15:0] a, output logic [15:0] q, output logic e);
        logic [7:0] c;
        u_master.xfer(1'b0, a, 16'h0000, q, e, c);
    endtask
    task automatic rd_chk(input logic [15:0] a, input logic [15:0] exp, input logic e);
        logic [15:0] q;
        logic        x;
        rd_q(a, q, x);
        check(q, exp);
        check({15'h0, x}, {15'h0, e});
    endtask
    // a refused write must carry the device-failure code
    task automatic wr_chk(input logic [15:0] a, input logic [15:0] d, input logic e);
        logic [15:0] q;
        logic        x;
        logic [7:0]  c;
        u_master.xfer(1'b1, a, d, q, x, c);
        check({15'h0, x}, {15'h0, e});
        check({8'h0, c}, e ? {8'h0, EXC_DEVICE_FAIL} : 16'h0000);
    endtask
    task automatic msg(input logic [15:0] d);
        @(negedge clock);
        msg_v = 1'b1;
        msg_d = d;
        @(negedge clock);
        msg_v = 1'b0;
        msg_d = ~d;
        repeat (4) @(negedge clock);
    endtask
    task automatic test_done();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // -----------------------------------------
    // main sequence and watchdog
    // -----------------------------------------
    initial
    begin
        repeat (20000) @(posedge clock);
        failures++;
        test_done();
    end
    initial
    begin
        {msg_v, v_open, v_closed, pwr_ok, an_ok} = 5'b00001;
        {msg_d, an_raw, live, local_d} = '0;
        repeat (16) @(negedge clock);
        srst = 1'b0;
        live = 16'h0011;
        repeat (4) @(negedge clock);
        live = 16'h0000;
        repeat (4) @(negedge clock);
        check(fh, 16'h0011);
        rd_chk(OFS_FAULT_HIST, 16'h0011, 1'b0);
        for (int i = 0; i < 8; i++)
            rd_chk(cfg_a[i], 16'(lo[i]), 1'b0);
        rd_chk(OFS_CTRL_TYPE, 16'h0001, 1'b0);
        rd_chk(OFS_RSVD_LO, 16'h0000, 1'b0);
        rd_chk(OFS_RSVD_HI, 16'h0000, 1'b0);
        wr_chk(OFS_RSVD_LO, 16'h1234, 1'b1);
        rd_chk(OFS_PROJ_ID, 16'h00a5, 1'b0);
        rd_chk(OFS_DOC_ID, 16'h005a, 1'b0);
        rd_chk(OFS_FW_VER, 16'h0110, 1'b0);
        rd_chk(OFS_SERIAL, 16'h0001, 1'b0);
        rd_chk(OFS_SERIAL + 16'h1, 16'h0000, 1'b0);
        wr_chk(OFS_CTRL_TYPE, 16'h0000, 1'b1);
        rd_chk(16'h000f, 16'h0000, 1'b1);
        wr_chk(OFS_ADDRESS, 16'h0000, 1'b1);
        // legal top value, one past it where rj is set, read back, then a random legal value
        for (int i = 0; i < 8; i++)
        begin
            wr_chk(cfg_a[i], 16'(hi[i]), 1'b0);
            if (rj[i])
                wr_chk(cfg_a[i], 16'(hi[i] + 1), 1'b1);
            rd_chk(cfg_a[i], 16'(hi[i]), 1'b0);
            seed = xs(seed);
            local_d = seed[31:16];
            wr_chk(cfg_a[i], 16'(lo[i] + seed % (hi[i] - lo[i] + 1)), 1'b0);
        end
        foreach (cfg_a[i])
            wr_chk(cfg_a[i], i == 2 ? 16'd25 : i == 5 ? 16'd2 : i == 6 ? 16'd9 :
                   i == 7 ? 16'd5 : 16'h0000, 1'b0);
        check(st_addr, 16'h0001);
        rd_q(OFS_POWER_UP, pre, pe);
        pwr_ok = 1'b1;
        repeat (6) @(negedge clock);
        rd_chk(OFS_POWER_UP, pre + 16'h1, 1'b0);
        rd_chk(OFS_POWER_UP + 16'h1, 16'h0000, 1'b0);
        check(st_addr, 16'h0009);
        check(baud, 16'h0005);
        msg(16'd60);
        check({15'h0, c_to}, 16'h0000);
        check(pos, 16'd60);
        repeat (40) @(negedge clock);
        check({15'h0, c_to}, 16'h0001);
        check(pos, 16'd25);
        check(fh, 16'h0091);
        msg(16'd80);
        check(pos, 16'd80);
        wr_chk(OFS_CUTOFF, 16'd90, 1'b0);
        msg(16'd85);
        check(pos, 16'd0);
        wr_chk(OFS_CUTOFF, 16'd0, 1'b0);
        wr_chk(OFS_DEADBAND, 16'd10, 1'b0);
        msg(16'd50);
        msg(16'd55);
        check(pos, 16'd50);
        msg(16'd65);
        check(pos, 16'd65);
        wr_chk(OFS_TIMEOUT, 16'd0, 1'b0);
        repeat (40) @(negedge clock);
        check({15'h0, c_to}, 16'h0000);
        wr_chk(OFS_CTRL_SRC, 16'd1, 1'b0);
        wr_chk(OFS_TIMEOUT, 16'd2, 1'b0);
        repeat (40) @(negedge clock);
        check({15'h0, c_to}, 16'h0000);
        rd_chk(OFS_CTRL_SRC, 16'd1, 1'b0);
        an_ok = 1'b0;
        repeat (6) @(negedge clock);
        check(pos, 16'd25);
        an_raw = 16'h8000;
        repeat (6) @(negedge clock);
        rd_chk(OFS_ANALOG, 16'd100, 1'b0);
        seed = xs(seed);
        an_raw = seed[15:0];
        repeat (6) @(negedge clock);
        rd_chk(OFS_ANALOG, 16'((32'(an_raw) * 200) >> 16), 1'b0);
        v_open = 1'b1;
        // whole minutes of exposure give a count independent of tick phase
        repeat (1200) @(negedge clock);
        v_open = 1'b0;
        v_closed = 1'b1;
        repeat (600) @(negedge clock);
        v_closed = 1'b0;
        rd_chk(OFS_OPEN_TIME, 16'd2, 1'b0);
        rd_chk(OFS_OPEN_TIME + 16'h1, 16'd0, 1'b0);
        rd_chk(OFS_CLOSE_TIME, 16'd1, 1'b0);
        rd_chk(OFS_CLOSE_TIME + 16'h1, 16'd0, 1'b0);
        test_done();
    end
endmodule // testbench
